// ===== pcs_config_target.sv
// Notes on behaviour
// - Address line 20 high selects this device
// - Command reads 0x0022, never writable
// - Status reads all zeros, never writable
// - Class byte all ones, sub-class zero
// - First window is 32 double words
// - Second window is 16k double words
// - Third window is 16k double words
// - Fourth window reads zero, read-only
// - Wait in busy while frame is low
// - Take address on first frame-low edge
// - Claim only type 0, function 0, select high
// - Command 1010b reads, 1011b writes
// - Otherwise stay off the bus until idle
// - Decode and branch in the same cycle
// - Read latches address bits 7:2 as index
// - Read data waits for initiator ready
// - Present word with target ready and select
// - Read burst increments index, no wait
// - Write latches index, asserts ready and select
// - Write data waits for initiator ready
// - Only enabled byte lanes are written
// - Write burst increments index or ends
`timescale 1ns/1ns
`default_nettype none
`include "pcs_cfg.svh"
module pcs_config_target (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        FRAME_N_IN,
  input  wire logic        IRDY_N_IN,
  input  wire logic [3:0]  CBE_N_IN,
  input  wire logic [31:0] AD_IN,
  output logic      [31:0] AD_OUT,
  output logic             AD_OE_OUT,
  output logic             TRDY_N_OUT,
  output logic             TRDY_N_OE_OUT,
  output logic             DEVSEL_N_OUT,
  output logic             DEVSEL_N_OE_OUT,
  output logic      [31:0] CTRL_BASE_OUT,
  output logic      [31:0] TX_FIFO_BASE_OUT,
  output logic      [31:0] RX_FIFO_BASE_OUT,
  output logic      [7:0]  INT_LINE_OUT
);
  // ****************************************
  // Declarations
  // ****************************************
  pcs_pkg::pcs_state_e state_r;
  pcs_pkg::pcs_state_e state_nxt;
  pcs_pkg::pcs_idx_t   idx_r;
  pcs_pkg::pcs_idx_t   idx_nxt;
  pcs_pkg::pcs_word_t  ad_out_r;
  pcs_pkg::pcs_word_t  ad_out_nxt;

  logic addr_phase;
  logic addr_match;
  logic cfg_rd;
  logic cfg_wr;
  logic in_busy;
  logic in_idle;
  logic in_rd_wait;
  logic in_rd_data;
  logic in_wr_wait;
  logic in_wr_done;
  logic rd_next;
  logic wr_next;
  logic wr_take;
  logic target_drive;

  pcs_reg_if reg_bus ();

  // ****************************************
  // State decode
  // ****************************************
  assign in_busy    = (state_r == pcs_pkg::ST_BUSY);
  assign in_idle    = (state_r == pcs_pkg::ST_IDLE);
  assign in_rd_wait = (state_r == pcs_pkg::ST_RD_WAIT);
  assign in_rd_data = (state_r == pcs_pkg::ST_RD_DATA);
  assign in_wr_wait = (state_r == pcs_pkg::ST_WR_WAIT);
  assign in_wr_done = (state_r == pcs_pkg::ST_WR_DONE);

  // ****************************************
  // Address phase decode
  // ****************************************
  assign addr_phase = in_idle && !FRAME_N_IN;
  assign addr_match = (AD_IN[1:0] == `PCS_TYPE0)
                   && (AD_IN[`PCS_AD_FN_HI:`PCS_AD_FN_LO] == `PCS_FUNC0)
                   && AD_IN[`PCS_AD_IDSEL];
  assign cfg_rd = addr_phase && addr_match && (CBE_N_IN == `PCS_CMD_CFG_RD);
  assign cfg_wr = addr_phase && addr_match && (CBE_N_IN == `PCS_CMD_CFG_WR);

  // Burst continuation and write data capture
  assign rd_next = in_rd_data && !FRAME_N_IN;
  assign wr_next = in_wr_done && !FRAME_N_IN;
  assign wr_take = in_wr_wait && !IRDY_N_IN;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pcs_pkg::ST_BUSY: begin
        if (FRAME_N_IN) state_nxt = pcs_pkg::ST_IDLE;
      end
      pcs_pkg::ST_IDLE: begin
        if (cfg_rd) begin
          state_nxt = pcs_pkg::ST_RD_WAIT;
        end else if (cfg_wr) begin
          state_nxt = pcs_pkg::ST_WR_WAIT;
        end else if (!FRAME_N_IN) begin
          state_nxt = pcs_pkg::ST_BUSY;
        end
      end
      pcs_pkg::ST_RD_WAIT: begin
        if (!IRDY_N_IN) state_nxt = pcs_pkg::ST_RD_DATA;
      end
      pcs_pkg::ST_RD_DATA: begin
        if (FRAME_N_IN) begin
          state_nxt = pcs_pkg::ST_BUSY;
        end else if (!IRDY_N_IN) begin
          state_nxt = pcs_pkg::ST_RD_DATA;
        end else begin
          state_nxt = pcs_pkg::ST_RD_WAIT;
        end
      end
      pcs_pkg::ST_WR_WAIT: begin
        if (wr_take) state_nxt = pcs_pkg::ST_WR_DONE;
      end
      pcs_pkg::ST_WR_DONE: begin
        if (FRAME_N_IN) begin
          state_nxt = pcs_pkg::ST_BUSY;
        end else begin
          state_nxt = pcs_pkg::ST_WR_WAIT;
        end
      end
      default: begin
        state_nxt = pcs_pkg::ST_BUSY;
      end
    endcase
  end

  // ****************************************
  // Register index latch
  // ****************************************
  assign idx_nxt = (cfg_rd || cfg_wr)     ? AD_IN[`PCS_AD_IDX_HI:`PCS_AD_IDX_LO] :
                   (rd_next || wr_next)   ? idx_r + `PCS_IDX_STEP :
                                            idx_r;

  // Read data is fetched for the index that the next state presents
  assign ad_out_nxt = (state_nxt == pcs_pkg::ST_RD_DATA) ? reg_bus.rdata : ad_out_r;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      state_r  <= pcs_pkg::ST_BUSY;
      idx_r    <= `PCS_IDX_RST;
      ad_out_r <= `PCS_ZERO32;
    end else begin
      state_r  <= state_nxt;
      idx_r    <= idx_nxt;
      ad_out_r <= ad_out_nxt;
    end
  end

  // ****************************************
  // Register file port
  // ****************************************
  assign reg_bus.rd_index = idx_nxt;
  assign reg_bus.wr_en    = wr_take;
  assign reg_bus.wr_index = idx_r;
  assign reg_bus.wr_data  = AD_IN;
  assign reg_bus.wr_be_n  = CBE_N_IN;

  pcs_cfg_regs u_regs (
    .clk_in        (CLK_SYS_IN),
    .rst_n_in      (RST_N_IN),
    .bus           (reg_bus.regs),
    .ctrl_base_out (CTRL_BASE_OUT),
    .tx_base_out   (TX_FIFO_BASE_OUT),
    .rx_base_out   (RX_FIFO_BASE_OUT),
    .int_line_out  (INT_LINE_OUT)
  );

  // ****************************************
  // Bus drivers
  // ****************************************
  assign target_drive    = in_rd_data || in_wr_wait || in_wr_done;
  assign AD_OUT          = ad_out_r;
  assign AD_OE_OUT       = in_rd_data;
  assign TRDY_N_OUT      = !(in_rd_data || in_wr_wait);
  assign TRDY_N_OE_OUT   = target_drive;
  assign DEVSEL_N_OUT    = !(in_rd_data || in_wr_wait);
  assign DEVSEL_N_OE_OUT = target_drive;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RST_N_IN);

  sequence s_rd_claim;
    in_idle && cfg_rd ##1 in_rd_wait;
  endsequence

  sequence s_wr_claim;
    in_idle && cfg_wr ##1 in_wr_wait;
  endsequence

  sequence s_rd_entry;
    in_rd_wait && !IRDY_N_IN ##1 in_rd_data;
  endsequence

  sequence s_wr_take;
    in_wr_wait && !IRDY_N_IN ##1 in_wr_done;
  endsequence

  AST_IDSEL_REQ: assert property (
    in_rd_wait && $past(in_idle) |-> $past(AD_IN[`PCS_AD_IDSEL])
  ) else $error("Read claimed without select line high");

  AST_CMD_FIXED: assert property (
    in_rd_data && idx_r == `PCS_IDX_CMDSTAT |-> AD_OUT[15:0] == `PCS_CMD_VAL
  ) else $error("Command word is not the fixed value");

  AST_STAT_ZERO: assert property (
    in_rd_data && idx_r == `PCS_IDX_CMDSTAT |-> AD_OUT[31:16] == `PCS_STAT_VAL
  ) else $error("Status word is not zero");

  AST_CLASS_VAL: assert property (
    in_rd_data && idx_r == `PCS_IDX_CLASS
      |-> AD_OUT[31:24] == `PCS_CLASS_VAL && AD_OUT[23:8] == 16'h0000
  ) else $error("Class code fields wrong");

  AST_BAR0_SIZE: assert property (
    in_rd_data && idx_r == `PCS_IDX_BAR0 |-> AD_OUT[6:0] == 7'h00
  ) else $error("Control window low bits not zero");

  AST_BAR1_SIZE: assert property (
    in_rd_data && idx_r == `PCS_IDX_BAR1 |-> AD_OUT[15:0] == 16'h0000
  ) else $error("Transmit window low bits not zero");

  AST_BAR2_SIZE: assert property (
    in_rd_data && idx_r == `PCS_IDX_BAR2 |-> AD_OUT[15:0] == 16'h0000
  ) else $error("Receive window low bits not zero");

  AST_BAR3_ZERO: assert property (
    in_rd_data && idx_r == `PCS_IDX_BAR3 |-> AD_OUT == `PCS_ZERO32
  ) else $error("Fourth window not zero");

  AST_BUSY_HOLD: assert property (
    in_busy && !FRAME_N_IN |=> in_busy
  ) else $error("Left busy while frame low");

  AST_ADDR_TAKE: assert property (
    s_rd_claim |-> idx_r == $past(AD_IN[`PCS_AD_IDX_HI:`PCS_AD_IDX_LO])
  ) else $error("Address not taken on address phase");

  AST_TYPE_FUNC: assert property (
    in_idle && (AD_IN[1:0] != `PCS_TYPE0 || AD_IN[`PCS_AD_FN_HI:`PCS_AD_FN_LO] != `PCS_FUNC0)
      |=> !in_rd_wait && !in_wr_wait
  ) else $error("Claimed wrong type or function");

  AST_CMD_DECODE: assert property (
    in_wr_wait && $past(in_idle) |-> $past(CBE_N_IN) == `PCS_CMD_CFG_WR
  ) else $error("Write claimed with wrong command");

  AST_FOREIGN: assert property (
    addr_phase && !cfg_rd && !cfg_wr
      |=> in_busy && !DEVSEL_N_OE_OUT && !TRDY_N_OE_OUT && !AD_OE_OUT
  ) else $error("Foreign cycle not ignored");

  AST_NO_PAUSE: assert property (
    addr_phase && cfg_rd |=> in_rd_wait
  ) else $error("Decode took an extra clock");

  AST_RD_IDX: assert property (
    s_rd_claim ##1 in_rd_wait |-> idx_r == $past(idx_r)
  ) else $error("Read index moved while waiting");

  AST_RD_WAIT: assert property (
    in_rd_wait && IRDY_N_IN |=> in_rd_wait && TRDY_N_OUT && !AD_OE_OUT
  ) else $error("Read data presented before initiator ready");

  AST_RD_PRESENT: assert property (
    s_rd_entry |-> !TRDY_N_OUT && !DEVSEL_N_OUT && AD_OE_OUT && AD_OUT == $past(reg_bus.rdata)
  ) else $error("Read data phase not driven");

  AST_RD_BURST: assert property (
    in_rd_data && !FRAME_N_IN
      |=> idx_r == $past(idx_r) + `PCS_IDX_STEP
          && (($past(IRDY_N_IN) && in_rd_wait) || (!$past(IRDY_N_IN) && in_rd_data))
  ) else $error("Read burst step wrong");

  AST_WR_CLAIM: assert property (
    s_wr_claim |-> !TRDY_N_OUT && !DEVSEL_N_OUT && TRDY_N_OE_OUT && !AD_OE_OUT
  ) else $error("Write claim not signalled");

  AST_WR_WAIT: assert property (
    in_wr_wait && IRDY_N_IN |-> !reg_bus.wr_en ##1 in_wr_wait
  ) else $error("Write taken before initiator ready");

  AST_BYTE_KEEP: assert property (
    wr_take && idx_r == `PCS_IDX_INTR && CBE_N_IN[0] |=> INT_LINE_OUT == $past(INT_LINE_OUT)
  ) else $error("Disabled byte lane changed");

  AST_BYTE_LOAD: assert property (
    wr_take && idx_r == `PCS_IDX_INTR && !CBE_N_IN[0] |=> INT_LINE_OUT == $past(AD_IN[7:0])
  ) else $error("Enabled byte lane not written");

  AST_WR_BURST: assert property (
    in_wr_done && !FRAME_N_IN |=> in_wr_wait && idx_r == $past(idx_r) + `PCS_IDX_STEP
  ) else $error("Write burst step wrong");

  AST_WR_END: assert property (
    in_wr_done && FRAME_N_IN |=> in_busy ##1 in_idle
  ) else $error("Write did not end on frame high");

  AST_UNIMPL_ZERO: assert property (
    in_rd_data && idx_r > `PCS_IDX_LAST |-> AD_OUT == `PCS_ZERO32
  ) else $error("Unimplemented word not zero");

  AST_BAR_SIZING: assert property (
    wr_take && idx_r == `PCS_IDX_BAR1 && CBE_N_IN == 4'h0 && AD_IN == 32'hffffffff
      |=> TX_FIFO_BASE_OUT == `PCS_BAR12_MASK
  ) else $error("Window sizing pattern wrong");

  AST_RD_END: assert property (
    in_rd_data && FRAME_N_IN |=> in_busy && !AD_OE_OUT && !TRDY_N_OE_OUT
  ) else $error("Read did not end on frame high");

  AST_QUIET: assert property (
    in_busy || in_idle || in_rd_wait |-> !AD_OE_OUT && !TRDY_N_OE_OUT && !DEVSEL_N_OE_OUT
  ) else $error("Bus driven outside a claimed phase");

  AST_WR_STEP: assert property (
    s_wr_take |-> TRDY_N_OUT && TRDY_N_OE_OUT && DEVSEL_N_OE_OUT && !AD_OE_OUT
  ) else $error("Write data phase not closed");

  AST_WR_NO_AD: assert property (
    in_wr_wait || in_wr_done |-> !AD_OE_OUT
  ) else $error("Data lines driven during a write");
endmodule
`default_nettype wire

// ===== pcs_cfg.svh
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

// ****************************************
// Configuration double word indices
// ****************************************
`define PCS_IDX_ID       6'h00
`define PCS_IDX_CMDSTAT  6'h01
`define PCS_IDX_CLASS    6'h02
`define PCS_IDX_MISC     6'h03
`define PCS_IDX_BAR0     6'h04
`define PCS_IDX_BAR1     6'h05
`define PCS_IDX_BAR2     6'h06
`define PCS_IDX_BAR3     6'h07
`define PCS_IDX_CIS      6'h0a
`define PCS_IDX_SUBSYS   6'h0b
`define PCS_IDX_ROM      6'h0c
`define PCS_IDX_INTR     6'h0f
`define PCS_IDX_LAST     6'h0f

// ****************************************
// Fixed field values and write masks
// ****************************************
`define PCS_CMD_VAL      16'h0022
`define PCS_STAT_VAL     16'h0000
`define PCS_CLASS_VAL    8'hff
`define PCS_SUBCLASS_VAL 8'h00
`define PCS_PROGIF_VAL   8'h00
`define PCS_INT_PIN_VAL  8'h01
`define PCS_INT_LINE_RST 8'hff
`define PCS_BAR0_MASK    32'hffffff80
`define PCS_BAR12_MASK   32'hffff0000
`define PCS_INTR_MASK    32'h000000ff
`define PCS_ZERO32       32'h00000000

// ****************************************
// Address phase decode
// ****************************************
`define PCS_CMD_CFG_RD   4'ha
`define PCS_CMD_CFG_WR   4'hb
`define PCS_TYPE0        2'h0
`define PCS_FUNC0        3'h0
`define PCS_AD_IDSEL     20
`define PCS_AD_IDX_HI    7
`define PCS_AD_IDX_LO    2
`define PCS_AD_FN_HI     10
`define PCS_AD_FN_LO     8
`define PCS_IDX_STEP     6'h01
`define PCS_IDX_RST      6'h00

`endif

// ===== pcs_pkg.sv
package pcs_pkg;
  typedef logic [5:0]  pcs_idx_t;
  typedef logic [31:0] pcs_word_t;
  typedef enum logic [5:0] {
    ST_BUSY    = 6'h01,
    ST_IDLE    = 6'h02,
    ST_RD_WAIT = 6'h04,
    ST_RD_DATA = 6'h08,
    ST_WR_WAIT = 6'h10,
    ST_WR_DONE = 6'h20
  } pcs_state_e;
endpackage

// ===== pcs_reg_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pcs_reg_if;
  pcs_pkg::pcs_idx_t  rd_index;
  pcs_pkg::pcs_word_t rdata;
  logic               wr_en;
  pcs_pkg::pcs_idx_t  wr_index;
  pcs_pkg::pcs_word_t wr_data;
  logic [3:0]         wr_be_n;
  modport ctrl (output rd_index, wr_en, wr_index, wr_data, wr_be_n, input rdata);
  modport regs (input rd_index, wr_en, wr_index, wr_data, wr_be_n, output rdata);
endinterface
`default_nettype wire

// ===== pcs_cfg_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "pcs_cfg.svh"
module pcs_cfg_regs #(
  parameter logic [15:0] VENDOR_CODE = 16'h5a17, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h3c6e, // Arbitrary value
  parameter logic [7:0]  REV_CODE    = 8'h2d,    // Arbitrary value
  parameter logic [15:0] SUBSYS_CODE = 16'h71b4, // Arbitrary value
  parameter logic [15:0] SUBVEN_CODE = 16'h6e29  // Arbitrary value
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  pcs_reg_if.regs         bus,
  output logic [31:0]     ctrl_base_out,
  output logic [31:0]     tx_base_out,
  output logic [31:0]     rx_base_out,
  output logic [7:0]      int_line_out
);
  // ****************************************
  // Byte lane merge
  // ****************************************
  function automatic pcs_pkg::pcs_word_t pcs_merge(input pcs_pkg::pcs_word_t old_w,
                                                   input pcs_pkg::pcs_word_t new_w,
                                                   input logic [3:0] be_n,
                                                   input pcs_pkg::pcs_word_t mask);
    pcs_pkg::pcs_word_t res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (!be_n[b]) res[b*8 +: 8] = new_w[b*8 +: 8];
    end
    return res & mask;
  endfunction

  pcs_pkg::pcs_word_t bar0_r;
  pcs_pkg::pcs_word_t bar1_r;
  pcs_pkg::pcs_word_t bar2_r;
  logic [7:0]         int_line_r;
  pcs_pkg::pcs_idx_t  ri;
  pcs_pkg::pcs_word_t intr_w;

  // ****************************************
  // Writable fields
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bar0_r     <= `PCS_ZERO32;
      bar1_r     <= `PCS_ZERO32;
      bar2_r     <= `PCS_ZERO32;
      int_line_r <= `PCS_INT_LINE_RST;
    end else if (bus.wr_en) begin
      if (bus.wr_index == `PCS_IDX_BAR0) begin
        bar0_r <= pcs_merge(bar0_r, bus.wr_data, bus.wr_be_n, `PCS_BAR0_MASK);
      end else if (bus.wr_index == `PCS_IDX_BAR1) begin
        bar1_r <= pcs_merge(bar1_r, bus.wr_data, bus.wr_be_n, `PCS_BAR12_MASK);
      end else if (bus.wr_index == `PCS_IDX_BAR2) begin
        bar2_r <= pcs_merge(bar2_r, bus.wr_data, bus.wr_be_n, `PCS_BAR12_MASK);
      end else if (bus.wr_index == `PCS_IDX_INTR) begin
        int_line_r <= intr_w[7:0];
      end
    end
  end

  assign intr_w = pcs_merge({24'h000000, int_line_r}, bus.wr_data, bus.wr_be_n,
                            `PCS_INTR_MASK);

  // ****************************************
  // Read selection
  // ****************************************
  assign ri = bus.rd_index;
  assign bus.rdata =
    (ri == `PCS_IDX_ID)      ? {DEVICE_CODE, VENDOR_CODE} :
    (ri == `PCS_IDX_CMDSTAT) ? {`PCS_STAT_VAL, `PCS_CMD_VAL} :
    (ri == `PCS_IDX_CLASS)   ? {`PCS_CLASS_VAL, `PCS_SUBCLASS_VAL, `PCS_PROGIF_VAL,
                                REV_CODE} :
    (ri == `PCS_IDX_BAR0)    ? bar0_r :
    (ri == `PCS_IDX_BAR1)    ? bar1_r :
    (ri == `PCS_IDX_BAR2)    ? bar2_r :
    (ri == `PCS_IDX_SUBSYS)  ? {SUBSYS_CODE, SUBVEN_CODE} :
    (ri == `PCS_IDX_INTR)    ? {16'h0000, `PCS_INT_PIN_VAL, int_line_r} :
                               `PCS_ZERO32;

  assign ctrl_base_out = bar0_r;
  assign tx_base_out   = bar1_r;
  assign rx_base_out   = bar2_r;
  assign int_line_out  = int_line_r;
endmodule
`default_nettype wire

// ===== pcs_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Host bridge initiator model
// ****************************************
module pcs_host_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] ad_in,
  input  wire logic        ad_oe_in,
  input  wire logic        trdy_n_in,
  input  wire logic        trdy_n_oe_in,
  input  wire logic        devsel_n_in,
  input  wire logic        devsel_n_oe_in,
  output logic      [31:0] ad_out,
  output logic      [3:0]  cbe_n_out,
  output logic             frame_n_out,
  output logic             irdy_n_out
);
  logic [31:0] wq[$];
  logic [3:0]  bq[$];
  logic [31:0] rq[$];
  int          cyc = 0;
  int          a0 = 0;
  int          lat = -1;
  bit          drove;
  bit          dsel_bad;
  wire logic   trdy_seen = trdy_n_oe_in && (trdy_n_in === 1'b0);

  initial begin
    ad_out      = 32'h0;
    cbe_n_out   = 4'hf;
    frame_n_out = 1'b1;
    irdy_n_out  = 1'b1;
  end

  // Cycle count, target activity and first ready latency
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (ad_oe_in || trdy_n_oe_in || devsel_n_oe_in)
      drove = 1'b1;
    if (trdy_seen && lat < 0)
      lat <= cyc - a0;
  end

  // One transaction; gives up after six edges without target ready
  task automatic run(input logic [31:0] addr, input logic [3:0] cmd, input int n,
                     input int wt, output bit ok);
    int k;
    int t;
    int w;
    bit wr;
    wr       = cmd[0];
    ok       = 1'b1;
    drove    = 1'b0;
    dsel_bad = 1'b0;
    lat      = -1;
    rq.delete();
    @(posedge clk_in);
    #1;
    frame_n_out = 1'b0;
    ad_out      = addr;
    cbe_n_out   = cmd;
    @(posedge clk_in);
    a0 = cyc;
    for (k = 0; k < n && ok; k++) begin
      #1;
      ad_out    = (wr && k < wq.size()) ? wq[k] : ~ad_out;
      cbe_n_out = (wr && k < bq.size()) ? bq[k] : cmd;
      w = (k == 0) ? wt : (wr ? ((wt > 0) ? wt : 1) : 0);
      if (w > 0) begin
        irdy_n_out = 1'b1;
        repeat (w) begin
          @(posedge clk_in);
          #1;
        end
      end
      irdy_n_out  = 1'b0;
      frame_n_out = (k == n - 1);
      t = 0;
      do begin
        @(posedge clk_in);
        t++;
      end while (!trdy_seen && t < 6);
      if (!trdy_seen)
        ok = 1'b0;
      else begin
        if (!(devsel_n_oe_in && devsel_n_in === 1'b0))
          dsel_bad = 1'b1;
        if (!wr)
          rq.push_back(ad_in);
      end
    end
    #1;
    frame_n_out = 1'b1;
    irdy_n_out  = 1'b1;
    ad_out      = ~ad_out;
    cbe_n_out   = ~cbe_n_out;
    if (wr && ok)
      @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// ===== pcs_config_target_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "pcs_cfg.svh"
module pcs_config_target_tb;
  localparam logic [31:0] ID_WORD  = 32'h3c6e5a17; // Arbitrary value
  localparam logic [31:0] SUB_WORD = 32'h71b46e29; // Arbitrary value
  localparam logic [7:0]  REV_BYTE = 8'h2d;        // Arbitrary value
  localparam int          LIMIT    = 20000;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] ad_host, ad_dut, ad_wire, ctrl_base, tx_base, rx_base;
  logic [3:0]  cbe_n;
  logic        frame_n, irdy_n, ad_oe, trdy_n, trdy_oe, devsel_n, devsel_oe;
  logic [7:0]  int_line;
  logic [31:0] exp_reg [64];
  logic [31:0] bad_mask [8] = '{32'h00100000, 32'h1, 32'h2, 32'h3,
                                32'h100, 32'h200, 32'h400, 32'h700};
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cycles = 0;
  bit          ok;

  assign ad_wire = ad_oe ? ad_dut : ad_host;
  always #5 clk = ~clk;

  pcs_config_target dut (
    .CLK_SYS_IN       (clk),
    .RST_N_IN         (rst_n),
    .FRAME_N_IN       (frame_n),
    .IRDY_N_IN        (irdy_n),
    .CBE_N_IN         (cbe_n),
    .AD_IN            (ad_wire),
    .AD_OUT           (ad_dut),
    .AD_OE_OUT        (ad_oe),
    .TRDY_N_OUT       (trdy_n),
    .TRDY_N_OE_OUT    (trdy_oe),
    .DEVSEL_N_OUT     (devsel_n),
    .DEVSEL_N_OE_OUT  (devsel_oe),
    .CTRL_BASE_OUT    (ctrl_base),
    .TX_FIFO_BASE_OUT (tx_base),
    .RX_FIFO_BASE_OUT (rx_base),
    .INT_LINE_OUT     (int_line)
  );

  pcs_host_model host (
    .clk_in         (clk),
    .ad_in          (ad_wire),
    .ad_oe_in       (ad_oe),
    .trdy_n_in      (trdy_n),
    .trdy_n_oe_in   (trdy_oe),
    .devsel_n_in    (devsel_n),
    .devsel_n_oe_in (devsel_oe),
    .ad_out         (ad_host),
    .cbe_n_out      (cbe_n),
    .frame_n_out    (frame_n),
    .irdy_n_out     (irdy_n)
  );

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
    num_checks++;
    if (got !== expv) begin
      $display("wrong value %s expected %h seen %h", what, expv, got);
      error_cnt++;
    end
  endtask

  function automatic logic [31:0] wmask(input logic [5:0] idx);
    case (idx)
      `PCS_IDX_BAR0:                return 32'hffffff80;
      `PCS_IDX_BAR1, `PCS_IDX_BAR2: return 32'hffff0000;
      `PCS_IDX_INTR:                return 32'h000000ff;
      default:                      return 32'h00000000;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be_n, input logic [31:0] m);
    logic [31:0] lanes;
    for (int i = 0; i < 4; i++)
      lanes[8*i+:8] = {8{~be_n[i]}};
    return (old & ~(lanes & m)) | (d & lanes & m);
  endfunction

  function automatic logic [31:0] cfg_addr(input logic [5:0] idx);
    return ($urandom & 32'hffeff800) | 32'h00100000 | {24'h0, idx, 2'b00};
  endfunction

  task automatic reset_model();
    foreach (exp_reg[i])
      exp_reg[i] = 32'h0;
    exp_reg[`PCS_IDX_ID]      = ID_WORD;
    exp_reg[`PCS_IDX_CMDSTAT] = {16'h0000, 16'h0022};
    exp_reg[`PCS_IDX_CLASS]   = {8'hff, 8'h00, 8'h00, REV_BYTE};
    exp_reg[`PCS_IDX_SUBSYS]  = SUB_WORD;
    exp_reg[`PCS_IDX_INTR]    = 32'h000001ff;
  endtask

  task automatic outs();
    chk("control base", exp_reg[`PCS_IDX_BAR0], ctrl_base);
    chk("transmit base", exp_reg[`PCS_IDX_BAR1], tx_base);
    chk("receive base", exp_reg[`PCS_IDX_BAR2], rx_base);
    chk("interrupt line", {24'h0, exp_reg[`PCS_IDX_INTR][7:0]}, {24'h0, int_line});
  endtask

  task automatic rd(input logic [5:0] idx, input int n, input int wt);
    host.run(cfg_addr(idx), 4'ha, n, wt, ok);
    chk("read claimed", 32'h1, {31'h0, ok});
    chk("read latency", wt + 2, host.lat);
    chk("read select", 32'h0, {31'h0, host.dsel_bad});
    for (int k = 0; k < n; k++)
      chk($sformatf("word %h", 6'(idx + k)), exp_reg[6'(idx + k)], host.rq[k]);
  endtask

  task automatic wr(input logic [5:0] idx, input int n, input int wt,
                    input logic [31:0] dv, input int be);
    logic [31:0] d;
    logic [3:0]  b;
    for (int k = 0; k < n; k++) begin
      d = (be < 0) ? $urandom : dv;
      b = (be < 0) ? 4'($urandom) : 4'(be);
      host.wq.push_back(d);
      host.bq.push_back(b);
      exp_reg[6'(idx + k)] = merge(exp_reg[6'(idx + k)], d, b, wmask(6'(idx + k)));
    end
    host.run(cfg_addr(idx), 4'hb, n, wt, ok);
    host.wq.delete();
    host.bq.delete();
    chk("write claimed", 32'h1, {31'h0, ok});
    chk("write latency", 32'h1, host.lat);
    chk("write select", 32'h0, {31'h0, host.dsel_bad});
    outs();
  endtask

  task automatic refused(input logic [31:0] addr, input logic [3:0] cmd, input int n);
    host.run(addr, cmd, n, 0, ok);
    chk("refused", 32'h0, {31'h0, ok});
    chk("bus driven", 32'h0, {31'h0, host.drove});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  always @(posedge clk) begin
    cycles++;
    if (cycles > LIMIT) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(32'h27d87dcd));
    reset_model();
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    outs();
    rd(6'h00, 64, 3);
    rd(6'h3e, 4, 0);
    wr(6'h00, 16, 2, 32'hffffffff, 0);
    rd(6'h00, 16, 0);
    wr(6'h0f, 3, 0, 32'h5aa5c33c, 4'ha);
    wr(6'h0f, 1, 1, 32'h000000a5, 4'h1);
    rd(6'h0f, 3, 1);
    for (int c = 0; c < 16; c++)
      if (c != 10 && c != 11)
        refused(cfg_addr(6'(c)), 4'(c), 1 + c % 2);
    foreach (bad_mask[i])
      refused(cfg_addr(6'h05) ^ bad_mask[i], 4'ha + 4'(i % 2), 1);
    refused(~cfg_addr(6'h02), 4'ha, 2);
    rd(6'h02, 1, 0);
    repeat (40) begin
      if ($urandom % 2)
        wr(6'($urandom % 20), 1 + $urandom % 3, $urandom % 3, 32'h0, -1);
      else
        rd(6'($urandom % 20), 1 + $urandom % 3, $urandom % 3);
    end
    #1 rst_n = 1'b0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    reset_model();
    repeat (2) @(posedge clk);
    outs();
    rd(6'h00, 16, 0);
    give_verdict();
  end
endmodule
`default_nettype wire
